// file: core/cfw_defs.vh
`ifndef CFW_DEFS_VH
`define CFW_DEFS_VH

// ========================================
// Register byte offsets
`define CFW_REG_CTRL     8'h00
`define CFW_REG_CMD0     8'h04
`define CFW_REG_CMD4     8'h14
`define CFW_REG_REPLY0   8'h18
`define CFW_REG_REPLY1   8'h1c
`define CFW_REG_STAT     8'h20
`define CFW_REG_IRQ_STAT 8'h24
`define CFW_REG_IRQ_EN   8'h28
`define CFW_REG_IRQ_CLR  8'h2c
`define CFW_REG_TAG_TYPE 8'h30
`define CFW_REG_RD_CODE  8'h34

// ========================================
// Control fields
`define CFW_CTRL_START   0
`define CFW_CTRL_STOP    1

// ========================================
// Telegram layout
`define CFW_CMD_CONT     8'h24
`define CFW_CMD_SINGLE   8'h25
`define CFW_LEN_HI       7
`define CFW_LEN_LO       4
`define CFW_CHAN_HI      3
`define CFW_CHAN_LO      1
`define CFW_TOGGLE       0
`define CFW_DATA_FIRST   4

// ========================================
// Status codes and tag types
`define CFW_ST_OK        8'h00
`define CFW_ST_WR_FAIL   8'h04
`define CFW_ST_BAD_CMD   8'h05
`define CFW_TAGTYPE_RST  8'h00
`define CFW_TAGTYPE_COMP 8'h50
`define CFW_COMPAT_BYTES 5'd8

// ========================================
// Interrupt bits
`define CFW_IRQ_REPLY    0
`define CFW_IRQ_FAIL     1
`define CFW_IRQ_BAD      2
`define CFW_IRQ_W        3

`endif

// file: core/cfw_tagwr.v
`timescale 1ns/10ps
`include "cfw_defs.vh"

module cfw_tagwr (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         start,
  input  wire [4:0]   len,
  input  wire [127:0] data,
  output reg          done,
  output reg          ok,
  output wire         tag_req,
  output reg  [7:0]   tag_addr,
  output reg  [7:0]   tag_wdata,
  input  wire         tag_ack,
  input  wire         tag_err
);

  reg       busy_q;
  reg [4:0] idx_q;
  wire [3:0] nxt;

  assign tag_req = busy_q;
  assign nxt     = idx_q[3:0] + 4'h1;

  // ========================================
  // Byte sequencer, one tag byte per handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_q    <= 1'b0;
      idx_q     <= 5'h00;
      done      <= 1'b0;
      ok        <= 1'b0;
      tag_addr  <= 8'h00;
      tag_wdata <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q    <= 1'b1;
        idx_q     <= 5'h00;
        tag_addr  <= 8'h00;
        tag_wdata <= data[7:0];
      end else if (busy_q && tag_ack) begin
        if (tag_err) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          ok     <= 1'b0;
        end else if (idx_q == len - 5'd1) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          ok     <= 1'b1;
        end else begin
          idx_q     <= idx_q + 5'd1;
          tag_addr  <= {4'h0, nxt};
          tag_wdata <= data[nxt*8 +: 8];
        end
      end
    end
  end

endmodule

// file: core/cfw_top.v
`timescale 1ns/10ps
`include "cfw_defs.vh"

module cfw_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        tag_present,
  output wire        tag_req,
  output wire [7:0]  tag_addr,
  output wire [7:0]  tag_wdata,
  input  wire        tag_ack,
  input  wire        tag_err,
  output reg         irq
);

  localparam S_IDLE = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_BUSY = 3'd2;
  localparam S_GONE = 3'd3;

  // ========================================
  // Bus capture
  reg        aw_full_q;
  reg [7:0]  aw_addr_q;
  reg        w_full_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       wr_go;

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_full_q && w_full_q && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // ========================================
  // Registers
  reg  [31:0] cmd_q [0:4];
  reg  [7:0]  tag_type_q;
  reg  [2:0]  irq_en_q;
  reg  [2:0]  irq_stat_q;
  reg  [31:0] reply_q;
  reg  [31:0] code_q;
  reg  [4:0]  mem_base_q;
  reg  [2:0]  state_q;
  reg         single_q;
  reg  [7:0]  counter_q;
  reg  [2:0]  ev_d;
  wire        wr_ctrl;
  wire        wr_cmd;
  wire        wr_map;
  wire [2:0]  cmd_idx;
  wire        start_p;
  wire        stop_p;
  wire        clr_p;
  integer     b;

  assign cmd_idx = aw_addr_q[4:2] - 3'd1;
  assign wr_ctrl = wr_go && aw_addr_q == `CFW_REG_CTRL;
  assign wr_cmd  = wr_go && aw_addr_q >= `CFW_REG_CMD0 &&
                   aw_addr_q <= `CFW_REG_CMD4 && aw_addr_q[1:0] == 2'b00;
  assign wr_map  = wr_ctrl || wr_cmd ||
                   aw_addr_q == `CFW_REG_IRQ_EN ||
                   aw_addr_q == `CFW_REG_IRQ_CLR ||
                   aw_addr_q == `CFW_REG_TAG_TYPE;
  assign start_p = wr_ctrl && w_strb_q[0] && w_data_q[`CFW_CTRL_START];
  assign stop_p  = wr_ctrl && w_strb_q[0] && w_data_q[`CFW_CTRL_STOP];
  assign clr_p   = wr_go && aw_addr_q == `CFW_REG_IRQ_CLR && w_strb_q[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (b = 0; b < 5; b = b + 1) begin
        cmd_q[b] <= 32'h0000_0000;
      end
      tag_type_q   <= `CFW_TAGTYPE_RST;
      irq_en_q     <= 3'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Byte lanes honoured on the telegram words
      if (wr_cmd) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (w_strb_q[b]) begin
            cmd_q[cmd_idx][b*8 +: 8] <= w_data_q[b*8 +: 8];
          end
        end
      end
      if (wr_go && aw_addr_q == `CFW_REG_IRQ_EN && w_strb_q[0]) begin
        irq_en_q <= w_data_q[2:0];
      end
      if (wr_go && aw_addr_q == `CFW_REG_TAG_TYPE && w_strb_q[0]) begin
        tag_type_q <= w_data_q[7:0];
      end
    end
  end

  // ========================================
  // Telegram fields
  wire [7:0]   cmd_code;
  wire [7:0]   cmd_hdr;
  wire [3:0]   fix_len;
  wire [127:0] fix_data;
  wire         compat;
  wire [4:0]   eng_len;
  wire         code_ok;

  assign cmd_code = cmd_q[0][7:0];
  assign cmd_hdr  = cmd_q[0][15:8];
  assign fix_len  = cmd_hdr[`CFW_LEN_HI:`CFW_LEN_LO];
  // Data starts at byte 4, so byte N = length + 3 lands in the window
  assign fix_data = {cmd_q[4], cmd_q[3], cmd_q[2], cmd_q[1]};
  // Type 50 selects compatibility layout for second-family tags
  assign compat   = tag_type_q == `CFW_TAGTYPE_COMP;
  assign eng_len  = compat ? `CFW_COMPAT_BYTES : {1'b0, fix_len};
  assign code_ok  = (cmd_code == `CFW_CMD_CONT ||
                     cmd_code == `CFW_CMD_SINGLE) && fix_len != 4'h0;

  // ========================================
  // Presence pin synchroniser
  reg tag_meta_q;
  reg tag_sync_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tag_meta_q <= 1'b0;
      tag_sync_q <= 1'b0;
    end else begin
      tag_meta_q <= tag_present;
      tag_sync_q <= tag_meta_q;
    end
  end

  // ========================================
  // Write engine
  reg  eng_start;
  wire eng_done;
  wire eng_ok;

  cfw_tagwr u_wr (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (eng_start),
    .len       (eng_len),
    .data      (fix_data),
    .done      (eng_done),
    .ok        (eng_ok),
    .tag_req   (tag_req),
    .tag_addr  (tag_addr),
    .tag_wdata (tag_wdata),
    .tag_ack   (tag_ack),
    .tag_err   (tag_err)
  );

  // ========================================
  // Command sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= S_IDLE;
      single_q   <= 1'b0;
      eng_start  <= 1'b0;
      counter_q  <= 8'h00;
      reply_q    <= 32'h0000_0000;
      code_q     <= 32'h0000_0000;
      mem_base_q <= 5'h00;
      ev_d       <= 3'h0;
    end else begin
      eng_start <= 1'b0;
      ev_d      <= 3'h0;
      case (state_q)
        S_IDLE: begin
          if (start_p) begin
            if (code_ok) begin
              single_q <= cmd_code == `CFW_CMD_SINGLE;
              state_q  <= S_WAIT;
            end else begin
              reply_q <= {counter_q + 8'h01, `CFW_ST_BAD_CMD,
                          cmd_hdr, cmd_code};
              counter_q            <= counter_q + 8'h01;
              ev_d[`CFW_IRQ_BAD]   <= 1'b1;
              ev_d[`CFW_IRQ_REPLY] <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          if (stop_p) begin
            state_q <= S_IDLE;
          end else if (tag_sync_q) begin
            eng_start <= 1'b1;
            state_q   <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (eng_done) begin
            if (eng_ok) begin
              // Echo code and header, status then counter
              reply_q <= {counter_q + 8'h01, `CFW_ST_OK,
                          cmd_hdr, cmd_code};
              counter_q            <= counter_q + 8'h01;
              ev_d[`CFW_IRQ_REPLY] <= 1'b1;
              code_q               <= fix_data[31:0];
              // Ordinary accesses start past the reserved header
              mem_base_q <= compat ? `CFW_COMPAT_BYTES : 5'h00;
              state_q    <= single_q ? S_IDLE : S_GONE;
            end else if (single_q) begin
              reply_q <= {counter_q + 8'h01, `CFW_ST_WR_FAIL,
                          cmd_hdr, cmd_code};
              counter_q            <= counter_q + 8'h01;
              ev_d[`CFW_IRQ_FAIL]  <= 1'b1;
              ev_d[`CFW_IRQ_REPLY] <= 1'b1;
              state_q              <= S_IDLE;
            end else begin
              ev_d[`CFW_IRQ_FAIL] <= 1'b1;
              state_q             <= S_WAIT;
            end
          end
        end
        S_GONE: begin
          // Same tag still in range must not be written twice
          if (stop_p) begin
            state_q <= S_IDLE;
          end else if (!tag_sync_q) begin
            state_q <= S_WAIT;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ========================================
  // Interrupts, set wins over clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(clr_p ? w_data_q[2:0] : 3'h0)) | ev_d;
      irq        <= |(irq_stat_q & irq_en_q);
    end
  end

  // ========================================
  // Read side
  reg [31:0] rd_d;
  reg        rd_err_d;

  always @* begin
    rd_d     = 32'h0000_0000;
    rd_err_d = 1'b0;
    case (s_axi_araddr)
      `CFW_REG_CTRL:     rd_d = 32'h0000_0000;
      8'h04:             rd_d = cmd_q[0];
      8'h08:             rd_d = cmd_q[1];
      8'h0c:             rd_d = cmd_q[2];
      8'h10:             rd_d = cmd_q[3];
      `CFW_REG_CMD4:     rd_d = cmd_q[4];
      `CFW_REG_REPLY0:   rd_d = reply_q;
      `CFW_REG_REPLY1:   rd_d = 32'h0000_0000;
      `CFW_REG_STAT:     rd_d = {19'h0, mem_base_q, 3'h0, single_q,
                                 tag_sync_q, state_q};
      `CFW_REG_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
      `CFW_REG_IRQ_EN:   rd_d = {29'h0, irq_en_q};
      `CFW_REG_IRQ_CLR:  rd_d = 32'h0000_0000;
      `CFW_REG_TAG_TYPE: rd_d = {24'h0, tag_type_q};
      // Four-byte code only offered under type 50
      `CFW_REG_RD_CODE:  rd_d = compat ? code_q : 32'h0000_0000;
      default:           rd_err_d = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_err_d ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: dv/cfw_top_sva.sv
`timescale 1ns/10ps
// ========================================
// Port checker for the fixed-code writer
module cfw_top_sva (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        tag_present,
  input logic        tag_req,
  input logic [7:0]  tag_addr,
  input logic [7:0]  tag_wdata,
  input logic        tag_ack,
  input logic        tag_err
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_byte_ok;
    tag_req && tag_ack && !tag_err;
  endsequence
  sequence s_byte_bad;
    tag_req && tag_ack && tag_err;
  endsequence

  a_req_hold: assert property (tag_req && !tag_ack |=>
    tag_req && $stable(tag_addr) && $stable(tag_wdata))
    else $error("tag request changed before ack");
  a_first_byte: assert property ($rose(tag_req) |->
    tag_addr == 8'h00)
    else $error("write sequence did not start at byte 0");
  a_next_byte: assert property (s_byte_ok ##1 tag_req |->
    tag_addr == $past(tag_addr) + 8'h01)
    else $error("tag address did not step by one");
  a_err_abort: assert property (s_byte_bad |=> !tag_req)
    else $error("tag request held after a failed byte");
  // Two sync stages, the wait state, then the engine's own step
  a_req_tag: assert property ($rose(tag_req) |->
    $past(tag_present, 4))
    else $error("tag request without a tag present");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("write response repeated");
  a_b_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read address taken without an answer");
endmodule

bind cfw_top cfw_top_sva SVA (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .tag_present, .tag_req, .tag_addr, .tag_wdata, .tag_ack, .tag_err);

// file: dv/cfw_tag_model.sv
`timescale 1ns/10ps
// ========================================
// Passive tag with random write latency
module cfw_tag_model (
  input  wire       aclk,
  input  wire       tag_req,
  input  wire [7:0] tag_addr,
  input  wire [7:0] tag_wdata,
  input  wire       fail,
  output reg        tag_ack,
  output reg        tag_err
);
  reg     [7:0] mem [0:15];
  reg     [1:0] wait_q;
  integer       n_wr;
  integer       n_err;
  integer       seed;

  initial begin
    tag_ack = 1'b0;
    tag_err = 1'b0;
    wait_q = 2'd0;
    n_wr = 0;
    n_err = 0;
    seed = 32'h5aef;
  end

  always @(posedge aclk) begin
    tag_ack <= 1'b0;
    // Error line means nothing outside an ack, so it wanders
    tag_err <= $random(seed);
    if (tag_req && !tag_ack) begin
      if (wait_q != 2'd0)
        wait_q <= wait_q - 2'd1;
      else begin
        tag_ack <= 1'b1;
        wait_q  <= $random(seed);
        tag_err <= fail;
        if (fail)
          n_err <= n_err + 1;
        else begin
          mem[tag_addr[3:0]] <= tag_wdata;
          n_wr <= n_wr + 1;
        end
      end
    end
  end
endmodule

// file: dv/test_continuous_fixcode_writer.sv
`timescale 1ns/10ps
`include "cfw_defs.vh"
module test_continuous_fixcode_writer;
  reg         aclk, aresetn, tag_present, fail;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        tag_req, tag_ack, tag_err;
  wire [7:0]  tag_addr, tag_wdata;
  integer     n_mismatch, compares, seed, cnt;
  reg  [7:0]  dat [0:15];

  cfw_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tag_present, .tag_req,
    .tag_addr, .tag_wdata, .tag_ack, .tag_err, .irq);
  cfw_tag_model TAG (.aclk, .tag_req, .tag_addr, .tag_wdata, .fail,
    .tag_ack, .tag_err);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ========================================
  // Checking and bus tasks
  task summarize;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer t;
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (t = 0; t < 100; t = t + 1) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) begin
          chk("bresp", er, s_axi_bresp);
          s_axi_bready <= 1'b0;
          t = 200;
        end
      end
      if (t == 100)
        chk("bwait", 1, 0);
    end
  endtask

  task rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
    integer t;
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (t = 0; t < 100; t = t + 1) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) begin
          chk("rresp", er, s_axi_rresp);
          chk("rdata", e, s_axi_rdata & m);
          s_axi_rready <= 1'b0;
          t = 200;
        end
      end
      if (t == 100)
        chk("rwait", 1, 0);
    end
  endtask

  task wait_irq;
    integer t;
    begin
      for (t = 0; t < 600 && irq !== 1'b1; t = t + 1)
        @(posedge aclk);
      chk("irq", 1, irq);
    end
  endtask

  // Second family: three hex then four decimal characters
  function [7:0] chr(input [3:0] len, input integer k, input [7:0] r);
    begin
      if (len != 4'd7)
        chr = r;
      else if (k < 3)
        chr = (r[3:0] < 4'ha) ? 8'h30 + r[3:0] : 8'h37 + r[3:0];
      else
        chr = 8'h30 + r % 10;
    end
  endfunction

  // ========================================
  // One command, then reps tag arrivals
  task run(input [7:0] code, input [3:0] len, input [15:0] typ,
           input [7:0] tt, input f, input [7:0] st, input integer reps);
    reg [7:0] hdr;
    integer   k, j, w, a0, nl;
    begin
      hdr = {len, 4'h0} | ($random(seed) & 8'h0f);
      for (k = 0; k < 16; k = k + 1)
        dat[k] = chr(len, k, $random(seed));
      nl = (tt == `CFW_TAGTYPE_COMP) ? 8 : len;
      wr(`CFW_REG_TAG_TYPE, tt, 2'b00);
      wr(`CFW_REG_CMD0, {typ[7:0], typ[15:8], hdr, code}, 2'b00);
      for (k = 1; k < 4; k = k + 1)
        wr(8'(4 * k + 4), {dat[4*k-1], dat[4*k-2], dat[4*k-3],
           dat[4*k-4]}, 2'b00);
      a0 = TAG.n_wr + TAG.n_err;
      wr(`CFW_REG_CTRL, 32'h1, 2'b00);
      for (j = 0; j < reps; j = j + 1) begin
        tag_present <= 1'b1;
        fail <= f && j == 0;
        if (f && j == 0) begin
          for (k = 0; k < 300 && TAG.n_wr + TAG.n_err == a0; k = k + 1)
            @(posedge aclk);
          if (reps > 1)
            fail <= 1'b0;
        end
        wait_irq;
        // Counter steps before each reply goes out
        cnt = cnt + 1;
        rd(`CFW_REG_REPLY0, {cnt[7:0], st, hdr, code}, 32'hffffffff,
           2'b00);
        rd(`CFW_REG_IRQ_STAT, {st == `CFW_ST_BAD_CMD, f && j == 0, 1'b1},
           32'h7, 2'b00);
        wr(`CFW_REG_IRQ_CLR, 32'h7, 2'b00);
        repeat (2) @(posedge aclk);
        chk("irq_clr", 0, irq);
        for (k = 0; k < nl && st == `CFW_ST_OK; k = k + 1)
          chk("tag_mem", dat[k], TAG.mem[k]);
        w = TAG.n_wr + TAG.n_err;
        repeat (30) @(posedge aclk);
        chk("no_rewrite", w, TAG.n_wr + TAG.n_err);
        tag_present <= 1'b0;
        repeat (8) @(posedge aclk);
      end
      if (st != `CFW_ST_OK)
        chk("attempts", a0 + (st == `CFW_ST_WR_FAIL),
            TAG.n_wr + TAG.n_err);
      fail <= 1'b0;
      wr(`CFW_REG_CTRL, 32'h2, 2'b00);
    end
  endtask

  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end

  initial begin
    seed = 32'h5aef;
    n_mismatch = 0;
    compares = 0;
    cnt = 0;
    aresetn = 1'b0;
    tag_present = 1'b0;
    fail = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CFW_REG_IRQ_STAT, 0, 32'h7, 2'b00);
    rd(`CFW_REG_TAG_TYPE, 0, 32'hff, 2'b00);
    rd(`CFW_REG_STAT, 0, 32'h1fff, 2'b00);
    rd(8'h40, 0, 32'hffffffff, 2'b10);
    wr(`CFW_REG_REPLY0, 32'h0, 2'b10);
    wr(8'h40, 32'h0, 2'b10);
    wr(`CFW_REG_IRQ_EN, 32'h5, 2'b00);
    rd(`CFW_REG_IRQ_EN, 32'h5, 32'h7, 2'b00);
    // Byte lanes on a telegram word
    wr(`CFW_REG_CMD4, 32'hffffffff, 2'b00);
    s_axi_wstrb <= 4'h2;
    wr(`CFW_REG_CMD4, 32'h0, 2'b00);
    s_axi_wstrb <= 4'hf;
    rd(`CFW_REG_CMD4, 32'hffff00ff, 32'hffffffff, 2'b00);
    run(`CFW_CMD_CONT, 4'd5, 16'h3032, 8'h00, 1'b0, 8'h00, 2);
    run(`CFW_CMD_CONT, 4'd5, 16'h3131, 8'h00, 1'b1, 8'h00, 2);
    run(`CFW_CMD_CONT, 4'd7, 16'h3532, 8'h50, 1'b0, 8'h00, 2);
    rd(`CFW_REG_STAT, 32'h0800, 32'h1f00, 2'b00);
    rd(`CFW_REG_RD_CODE, {dat[3], dat[2], dat[1], dat[0]}, 32'hffffffff,
       2'b00);
    run(`CFW_CMD_SINGLE, 4'd5, 16'h3032, 8'h00, 1'b1, 8'h04, 1);
    run(8'h3c, 4'd5, 16'h3032, 8'h00, 1'b0, 8'h05, 1);
    run(`CFW_CMD_CONT, 4'd0, 16'h3032, 8'h00, 1'b0, 8'h05, 1);
    summarize;
  end
endmodule
